// ==== verilog/pmsr_bank.sv ====
// Wishbone register bank that routes six photodiodes to three modulators per step
// Summary of operation
// [RULE_01] Each step has a selector per photodiode; step 2 here has none for diodes 4 and 5, which stay unrouted
// [RULE_02] 00 none, 01/10/11 modulators 0/1/2
// [RULE_03] Step 0 reset: diode5 mod0, diode4 mod1
// [RULE_04] Step 1 reset: d3 mod1, d2 none, d1 mod0, d0 none
// [RULE_05] Step 1 reset: diode5 none, diode4 mod2
// [RULE_06] Step 2 reset: d3,d2 none, d1 mod0, d0 mod2
// [RULE_07] Step-1 upper bits 7:4 hold saturation mask
// [RULE_08] Mask bits are independent per-step enables
// [RULE_09] Mask MSB is step 3, LSB step 0
// [RULE_10] Mask resets to all ones
// [RULE_11] Step 0 reset: d3 mod0, d2 mod1, d1 mod0, d0 mod1
// [RULE_12] Step-0 upper reserved bits read zero, ignore writes
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/10ps
`include "pmsr_regs.svh"
module pmsr_bank
  import pmsr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [7:0] wb_dat_i,
  input wire logic wb_sel_i,
  output logic [7:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // Sequencer side
  input wire logic [1:0] active_step,
  output logic [5:0] diode_to_mod0,
  output logic [5:0] diode_to_mod1,
  output logic [5:0] diode_to_mod2,
  output logic saturation_gain_enable,
  output logic [3:0] saturation_gain_step_mask
);
  pmsr_byte_t regs_ff [`PMSR_NUM_REGS];
  pmsr_bus_state_t bus_state_ff;
  pmsr_byte_t nxt_rdata;
  logic [3:0] adr_dec;
  logic [2:0] idx;
  logic hit;
  logic req;
  logic [11:0] step_sel;
  logic [3:0] mask;
  pmsr_route_if rt ();

  // Maps a byte offset to a register index; valid flag in bit 3
  function automatic logic [3:0] decode(input logic [7:0] a);
    unique case (a)
      `PMSR_OFF_STEP0_LOWER: decode = 4'h8;
      `PMSR_OFF_STEP0_UPPER: decode = 4'h9;
      `PMSR_OFF_STEP1_LOWER: decode = 4'hA;
      `PMSR_OFF_STEP1_UPPER: decode = 4'hB;
      `PMSR_OFF_STEP2_LOWER: decode = 4'hC;
      default: decode = 4'h0;
    endcase
  endfunction

  // Writable bits of each register
  function automatic pmsr_byte_t wmask(input logic [2:0] i);
    wmask = (i == 3'h1) ? `PMSR_UPPER_SEL_MASK : 8'hFF; // see [RULE_12]
  endfunction

  assign req = wb_cyc_i & wb_stb_i & (bus_state_ff == PMSR_BUS_IDLE);
  assign adr_dec = decode(wb_adr_i);
  assign idx = adr_dec[2:0];
  assign hit = adr_dec[3];

  // Bus handshake: one ack or err per request, then one idle cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      bus_state_ff <= PMSR_BUS_IDLE;
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end else begin
      unique case (bus_state_ff)
        PMSR_BUS_IDLE: begin
          wb_ack_o <= req & hit;
          wb_err_o <= req & ~hit;
          if (req) begin
            bus_state_ff <= PMSR_BUS_ACK;
          end
        end
        PMSR_BUS_ACK: begin
          wb_ack_o <= 1'b0;
          wb_err_o <= 1'b0;
          bus_state_ff <= PMSR_BUS_IDLE;
        end
      endcase
    end
  end

  // Register storage with documented reset routing
  always_ff @(posedge mclk) begin
    if (reset) begin
      regs_ff[0] <= `PMSR_RST_STEP0_LOWER; // see [RULE_11]
      regs_ff[1] <= `PMSR_RST_STEP0_UPPER; // see [RULE_03]
      regs_ff[2] <= `PMSR_RST_STEP1_LOWER; // see [RULE_04]
      regs_ff[3] <= `PMSR_RST_STEP1_UPPER; // see [RULE_05] see [RULE_10]
      regs_ff[4] <= `PMSR_RST_STEP2_LOWER; // see [RULE_06]
    end else if (req && hit && wb_we_i && wb_sel_i) begin
      regs_ff[idx] <= (wb_dat_i & wmask(idx)) | (regs_ff[idx] & ~wmask(idx));
    end
  end

  always_comb begin
    nxt_rdata = '0;
    if (hit) begin
      nxt_rdata = regs_ff[idx] & wmask(idx); // see [RULE_12]
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wb_dat_o <= '0;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= nxt_rdata;
    end
  end

  // Selector word of the active step: six 2-bit fields, diode 0 lowest
  always_comb begin
    unique case (active_step)
      2'h0: step_sel = {regs_ff[1][3:0], regs_ff[0]}; // see [RULE_01]
      2'h1: step_sel = {regs_ff[3][3:0], regs_ff[2]};
      2'h2: step_sel = {4'h0, regs_ff[4]};
      default: step_sel = '0;
    endcase
  end

  // Step 2 has no upper selector register; its upper half is forced to zero, so diodes 4 and 5 read as unrouted
  assign rt.sel = step_sel;
  assign mask = regs_ff[3][`PMSR_MASK_MSB:`PMSR_MASK_LSB]; // see [RULE_07]

  pmsr_route_dec pmsr_route_dec_inst (
    .rt(rt.dec)
  );

  always_ff @(posedge mclk) begin
    if (reset) begin
      diode_to_mod0 <= '0;
      diode_to_mod1 <= '0;
      diode_to_mod2 <= '0;
      saturation_gain_enable <= 1'b0;
      saturation_gain_step_mask <= '0;
    end else begin
      diode_to_mod0 <= rt.to_mod0;
      diode_to_mod1 <= rt.to_mod1;
      diode_to_mod2 <= rt.to_mod2;
      saturation_gain_enable <= mask[active_step]; // see [RULE_08] see [RULE_09]
      saturation_gain_step_mask <= mask;
    end
  end
endmodule // pmsr_bank

// ==== verilog/pmsr_regs.svh ====
// Register offsets, field positions and reset values of the diode routing bank
`ifndef PMSR_REGS_SVH
`define PMSR_REGS_SVH

`define PMSR_ADDR_W 8
`define PMSR_OFF_STEP0_LOWER 8'hDC
`define PMSR_OFF_STEP0_UPPER 8'hDD
`define PMSR_OFF_STEP1_LOWER 8'hDE
`define PMSR_OFF_STEP1_UPPER 8'hDF
`define PMSR_OFF_STEP2_LOWER 8'hE0

`define PMSR_RST_STEP0_LOWER 8'h66
`define PMSR_RST_STEP0_UPPER 8'h06
`define PMSR_RST_STEP1_LOWER 8'h84
`define PMSR_RST_STEP1_UPPER 8'hF3
`define PMSR_RST_STEP2_LOWER 8'h07

`define PMSR_UPPER_SEL_MASK 8'h0F
`define PMSR_MASK_LSB 4
`define PMSR_MASK_MSB 7
`define PMSR_SEL_W 2
`define PMSR_NUM_STEPS 3
`define PMSR_NUM_DIODES 6
`define PMSR_NUM_MODS 3
`define PMSR_NUM_REGS 5
`define PMSR_SEL_NONE 2'h0
`define PMSR_SEL_MOD0 2'h1
`define PMSR_SEL_MOD1 2'h2
`define PMSR_SEL_MOD2 2'h3

`endif

// ==== verilog/pmsr_pkg.sv ====
// Types shared by the diode routing bank
package pmsr_pkg;
  typedef logic [1:0] pmsr_sel_t;
  typedef logic [7:0] pmsr_byte_t;
  typedef enum logic [1:0] {
    PMSR_ROUTE_NONE,
    PMSR_ROUTE_MOD0,
    PMSR_ROUTE_MOD1,
    PMSR_ROUTE_MOD2
  } pmsr_route_t;
  typedef enum {
    PMSR_BUS_IDLE,
    PMSR_BUS_ACK
  } pmsr_bus_state_t;
endpackage

// ==== verilog/pmsr_route_if.sv ====
// Selector word of one step, handed from the register bank to the decoder
`timescale 1ns/10ps
interface pmsr_route_if;
  logic [11:0] sel;
  logic [5:0] to_mod0;
  logic [5:0] to_mod1;
  logic [5:0] to_mod2;
  modport bank (output sel, input to_mod0, input to_mod1, input to_mod2);
  modport dec (input sel, output to_mod0, output to_mod1, output to_mod2);
endinterface

// ==== verilog/pmsr_route_dec.sv ====
// Decodes the six diode selectors of one step into per-modulator connect masks
`timescale 1ns/10ps
`include "pmsr_regs.svh"
module pmsr_route_dec
  import pmsr_pkg::*;
(
  // Selector words in, masks out
  pmsr_route_if.dec rt
);
  always_comb begin
    rt.to_mod0 = '0;
    rt.to_mod1 = '0;
    rt.to_mod2 = '0;
    for (int d = 0; d < `PMSR_NUM_DIODES; d++) begin
      unique case (rt.sel[2*d +: 2]) // see [RULE_02]
        `PMSR_SEL_NONE: ;
        `PMSR_SEL_MOD0: rt.to_mod0[d] = 1'b1;
        `PMSR_SEL_MOD1: rt.to_mod1[d] = 1'b1;
        `PMSR_SEL_MOD2: rt.to_mod2[d] = 1'b1;
      endcase
    end
  end
endmodule // pmsr_route_dec

// ==== testbench/pmsr_bank_asserts.sv ====
// Port assertions for the diode routing bank
`timescale 1ns/10ps
module pmsr_bank_asserts (
  input wire logic mclk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i,
  input wire logic wb_ack_o, wb_err_o, saturation_gain_enable,
  input wire logic [7:0] wb_adr_i, wb_dat_i, wb_dat_o,
  input wire logic [1:0] active_step,
  input wire logic [5:0] diode_to_mod0, diode_to_mod1, diode_to_mod2,
  input wire logic [3:0] saturation_gain_step_mask
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire logic hit = wb_adr_i inside {[8'hDC:8'hE0]};
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  map_ack_a: assert property (req && hit |=> wb_ack_o && !wb_err_o) else $error("no ack");
  unmap_err_a: assert property (req && !hit |=> wb_err_o && !wb_ack_o)
    else $error("no err");
  unmap_rdzero_a: assert property (req && !hit && !wb_we_i |=> wb_dat_o == 8'h00)
    else $error("unmapped read data not zero");
  err_pulse_a: assert property (wb_err_o |=> !wb_err_o) else $error("err too long");
  rsvd_zero_a: assert property (req && !wb_we_i && wb_adr_i == 8'hDD |=>
    wb_dat_o[7:4] == 4'h0) else $error("reserved bits set");
  one_mod_a: assert property (((diode_to_mod0 & diode_to_mod1) |
    (diode_to_mod2 & (diode_to_mod0 | diode_to_mod1))) == 6'h00) else $error("two mods");
  step3_none_a: assert property (active_step == 2'h3 |=>
    (diode_to_mod0 | diode_to_mod1 | diode_to_mod2) == 6'h00) else $error("step 3 routed");
  mask_bit_a: assert property ($stable(saturation_gain_step_mask) && $stable(active_step)
    |-> saturation_gain_enable == saturation_gain_step_mask[active_step]) else $error("enable");
  mask_rst_a: assert property ($fell(reset) |=> saturation_gain_step_mask == 4'hF)
    else $error("mask reset");
endmodule // pmsr_bank_asserts
bind pmsr_bank pmsr_bank_asserts pmsr_bank_asserts_inst (.mclk(mclk), .reset(reset),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .saturation_gain_enable(saturation_gain_enable),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .active_step(active_step),
  .diode_to_mod0(diode_to_mod0), .diode_to_mod1(diode_to_mod1), .diode_to_mod2(diode_to_mod2),
  .saturation_gain_step_mask(saturation_gain_step_mask));

// ==== testbench/pmsr_bank_tb.sv ====
// Self-checking bench for the diode routing bank
`timescale 1ns/10ps
module pmsr_bank_tb;
  import pmsr_pkg::*;
  logic mclk = 0, reset = 1, cyc = 0, stb = 0, we = 0, sel = 1, ack, err, sge, e;
  logic [1:0] step = 0;
  logic [3:0] msk;
  logic [5:0] m0, m1, m2;
  pmsr_byte_t adr = 0, wd = 0, dat, rd;
  pmsr_byte_t md[5] = '{8'h66, 8'h06, 8'h84, 8'hF3, 8'h07};
  int mismatches = 0, samples_checked = 0;
  always #10 mclk = ~mclk;
  pmsr_bank pmsr_bank_inst (.mclk(mclk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i(sel), .wb_dat_o(dat),
    .wb_ack_o(ack), .wb_err_o(err), .active_step(step), .diode_to_mod0(m0),
    .diode_to_mod1(m1), .diode_to_mod2(m2), .saturation_gain_enable(sge),
    .saturation_gain_step_mask(msk));
  task automatic ck(string n, logic [7:0] x, logic [7:0] y);
    samples_checked++;
    if (y !== x) begin
      mismatches++;
      $display("ERROR %s exp %h got %h", n, x, y);
    end
  endtask
  // Called right after a rising edge; err and data are taken at the edge that samples ack or err high
  task automatic wb(logic w, pmsr_byte_t a, pmsr_byte_t d);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge mclk);
    end while (ack !== 1'b1 && err !== 1'b1);
    rd = dat;
    e = err;
    cyc <= 0;
    stb <= 0;
    @(posedge mclk);
  endtask
  function automatic logic [5:0] rt(logic [11:0] s, logic [1:0] c);
    for (int i = 0; i < 6; i++) rt[i] = (s[2*i+:2] == c);
  endfunction
  task automatic chk_rt(logic [1:0] s);
    logic [11:0] w;
    w = s == 0 ? {md[1][3:0], md[0]} : s == 1 ? {md[3][3:0], md[2]} : {4'h0, md[4]};
    if (s == 3) w = 12'h000;
    @(posedge mclk);
    step <= s;
    repeat (2) @(posedge mclk);
    ck("mod0", rt(w, 1), m0);
    ck("mod1", rt(w, 2), m1);
    ck("mod2", rt(w, 3), m2);
    ck("mask", md[3][7:4], msk);
    ck("enable", md[3][4+s], sge);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    int a;
    pmsr_byte_t d;
    void'($urandom(66));
    repeat (8) @(posedge mclk);
    reset <= 0;
    for (int i = 0; i < 5; i++) begin
      wb(0, pmsr_byte_t'(8'hDC + i), 0);
      ck("reset", md[i], rd);
    end
    for (int s = 0; s < 4; s++) chk_rt(2'(s));
    wb(1, 8'hDD, 8'hFF);
    md[1] = 8'h0F;
    wb(0, 8'hDD, 0);
    ck("reserved", 8'h0F, rd);
    sel <= 0;
    wb(1, 8'hDF, 8'h00);
    sel <= 1;
    wb(0, 8'hDF, 0);
    ck("lane", md[3], rd);
    wb(1, 8'hE1, 8'h55);
    ck("err", 1, e);
    wb(0, 8'hDB, 0);
    ck("err", 1, e);
    ck("errdat", 0, rd);
    repeat (40) begin
      a = $urandom % 5;
      d = pmsr_byte_t'($urandom);
      wb(1, pmsr_byte_t'(8'hDC + a), d);
      md[a] = a == 1 ? d & 8'h0F : d;
      wb(0, pmsr_byte_t'(8'hDC + a), 0);
      ck("readback", md[a], rd);
      chk_rt(2'($urandom % 4));
    end
    // Second reset in mid-run must bring back the reset routing
    reset <= 1;
    repeat (3) @(posedge mclk);
    reset <= 0;
    md = '{8'h66, 8'h06, 8'h84, 8'hF3, 8'h07};
    for (int i = 0; i < 5; i++) begin
      wb(0, pmsr_byte_t'(8'hDC + i), 0);
      ck("rereset", md[i], rd);
    end
    chk_rt(2'h1);
    wrap_up;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    mismatches++;
    wrap_up;
  end
endmodule // pmsr_bank_tb
